// [design/e1_ssm_cfg.svh]
`ifndef E1_SSM_CFG_SVH
`define E1_SSM_CFG_SVH
// Functional notes
// RL1: send each code MSB first, starting in multiframe frame 1.
// RL2: 4-bit quality codes: 0000,0010,0100,1000,1011,1111 defined; others reserved.
// RL3: source select clear picks national Sa bits, set picks Si bit.
// RL4: code insertion beats normal Sa traffic; software enables one Sa bit.
// RL5: Si reception needs CRC multiframe alignment and CRC config not 11.
// RL6: match filter 00/01/10/11 needs 1/3/5/7 identical codes, matches only.
// RL7: receive filter, same encoding, gates receive alarm and message update.
// RL8: receiver watches the overhead bit only while receive enable is set.
// RL9: writing reset bit restores all registers to defaults, then self-clears.
// RL10: send bit transmits the stored code and clears itself.
// RL11: qualified code enters low nibble, old low nibble moves high.
// RL12: three expected codes, each with its own filtered match alarm.
// RL13: change-of-status alarm when qualified code differs from the previous.
// RL14: repeat count sets repetitions before all ones; zero repeats forever.
// RL15: software ends continuous sending by nonzero count plus new send.
// RL16: code insertion runs by itself in every odd frame once started; the code inserts only in the odd frames.
// RL17: received FAS Si bits captured only at the multiframe boundary.
// RL18: FAS Si transmit register, overridden by code sending on Si.
// RL19: reserved upper nibbles ignored on write and read as zero.
// RL20: after the repetitions, all ones are sent until the next send.

// register offsets
`define SSM_ADDR_CTRL     16'h0170
`define SSM_ADDR_RXCODE   16'h0171
`define SSM_ADDR_EXP1     16'h0172
`define SSM_ADDR_EXP2     16'h0173
`define SSM_ADDR_EXP3     16'h0174
`define SSM_ADDR_TXCODE   16'h0175
`define SSM_ADDR_REPEAT   16'h0176
`define SSM_ADDR_FASRX    16'h0177
`define SSM_ADDR_FASTX    16'h0178
// control field positions
`define SSM_CTRL_SRC      7
`define SSM_CTRL_MF_HI    6
`define SSM_CTRL_MF_LO    5
`define SSM_CTRL_RXEN     4
`define SSM_CTRL_RST      3
`define SSM_CTRL_RF_HI    2
`define SSM_CTRL_RF_LO    1
`define SSM_CTRL_SEND     0
// reset values
`define SSM_CTRL_RST_VAL  8'h00
`define SSM_REPEAT_RST    8'h01
// quality level codes
`define SSM_QL_UNKNOWN    4'h0
`define SSM_QL_PRC        4'h2
`define SSM_QL_SSU_A      4'h4
`define SSM_QL_SSU_B      4'h8
`define SSM_QL_SEC        4'hb
`define SSM_QL_DNU        4'hf
// timing within the crc multiframe, frames counted from 0
`define SSM_FIRST_FRAME   3'h1
`define SSM_LAST_FRAME    3'h7
`define SSM_MF_LAST       4'hf
`define SSM_CRC_CFG_BAD   2'h3
`endif

// [design/e1_ssm_pkg.sv]
package e1_ssm_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_ONES} tx_state_e;
    typedef struct packed {
        logic       frame_stb;
        logic [3:0] frame_num;
        logic       sa_bit;
        logic       si_bit;
        logic       bit_err;
    } rx_link_s;
    typedef struct packed {
        logic       frame_stb;
        logic [3:0] frame_num;
    } tx_timing_s;
    typedef struct packed {
        logic sa_ins;
        logic sa_bit;
        logic si_bit;
    } tx_out_s;
    typedef struct packed {
        logic       rx_code_alarm;
        logic       cos_alarm;
        logic [2:0] match_alarm;
    } rx_events_s;
endpackage : e1_ssm_pkg

// [design/e1_ssm_boc_controller.sv]
`timescale 1ns/1ps
`include "e1_ssm_cfg.svh"
module e1_ssm_boc_controller (
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_n_i,
    // register port
    input  wire logic [15:0]           addr_i,
    input  wire logic [7:0]            wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [7:0]                 rdata_o,
    // framer receive side
    input  wire e1_ssm_pkg::rx_link_s  rx_link_i,
    input  wire logic                  crc_mf_align_en_i,
    input  wire logic [1:0]            crc_multiframe_config_i,
    // framer transmit side
    input  wire e1_ssm_pkg::tx_timing_s tx_timing_i,
    output e1_ssm_pkg::tx_out_s        tx_out_o,
    // receive events, one-cycle pulses
    output e1_ssm_pkg::rx_events_s     rx_events_o
);
    logic [7:0] ctrl_r;
    logic       sw_rst_r;
    logic [7:0] rx_code_r;
    logic [3:0] exp_r [3];
    logic [3:0] outgoing_code;
    logic [7:0] repeat_count_value;
    logic [7:0] captured_fas_intl_bits;
    logic [7:0] outgoing_fas_intl_bits;
    logic [7:0] fas_sh_r;
    logic       code_source_select;
    logic       code_receive_enable;
    logic       code_send_strobe;
    logic [1:0] match_filter_depth;
    logic [1:0] receive_filter_depth;
    logic       wr_ctrl;

    assign code_source_select   = ctrl_r[`SSM_CTRL_SRC];
    assign code_receive_enable  = ctrl_r[`SSM_CTRL_RXEN];
    assign code_send_strobe     = ctrl_r[`SSM_CTRL_SEND];
    assign match_filter_depth   = ctrl_r[`SSM_CTRL_MF_HI:`SSM_CTRL_MF_LO];
    assign receive_filter_depth = ctrl_r[`SSM_CTRL_RF_HI:`SSM_CTRL_RF_LO];
    assign wr_ctrl              = wr_i && (addr_i == `SSM_ADDR_CTRL);

    function automatic logic [2:0] depth_of(input logic [1:0] sel);
        depth_of = {sel, 1'b1};
    endfunction : depth_of

    // transmit timing
    logic       tx_odd;
    logic       tx_start;
    logic       tx_end;
    logic [3:0] tx_code_r;
    logic [7:0] tx_rem_r;
    e1_ssm_pkg::tx_state_e tx_state_r;
    logic       tx_ins;
    logic       tx_bit;
    logic       fas_bit;

    assign tx_odd   = tx_timing_i.frame_stb && tx_timing_i.frame_num[0];
    assign tx_start = tx_odd && code_send_strobe
                      && (tx_timing_i.frame_num[2:0] == `SSM_FIRST_FRAME);
    assign tx_end   = tx_odd
                      && (tx_timing_i.frame_num[2:0] == `SSM_LAST_FRAME);

    // control register: soft reset and send bits clear themselves
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r   <= `SSM_CTRL_RST_VAL;
            sw_rst_r <= 1'b0;
        end else begin
            sw_rst_r <= wr_ctrl && wdata_i[`SSM_CTRL_RST]; // [RL9]
            if (sw_rst_r) begin
                ctrl_r <= `SSM_CTRL_RST_VAL; // [RL9]
            end else if (wr_ctrl) begin
                ctrl_r <= wdata_i;
                ctrl_r[`SSM_CTRL_RST] <= 1'b0; // [RL9]
                // a write of one in the start cycle wins over the clear
                if (!wdata_i[`SSM_CTRL_SEND] && tx_start) begin
                    ctrl_r[`SSM_CTRL_SEND] <= 1'b0;
                end
            end else if (tx_start) begin
                ctrl_r[`SSM_CTRL_SEND] <= 1'b0; // [RL10]
            end
        end
    end

    // software written registers, reserved nibbles not stored
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exp_r                  <= '{default: 4'h0};
            outgoing_code          <= 4'h0;
            repeat_count_value     <= `SSM_REPEAT_RST;
            outgoing_fas_intl_bits <= 8'h00;
        end else if (sw_rst_r) begin
            exp_r                  <= '{default: 4'h0};
            outgoing_code          <= 4'h0;
            repeat_count_value     <= `SSM_REPEAT_RST; // [RL14]
            outgoing_fas_intl_bits <= 8'h00;
        end else if (wr_i) begin
            case (addr_i)
                `SSM_ADDR_EXP1:   exp_r[0] <= wdata_i[3:0]; // [RL19]
                `SSM_ADDR_EXP2:   exp_r[1] <= wdata_i[3:0];
                `SSM_ADDR_EXP3:   exp_r[2] <= wdata_i[3:0];
                `SSM_ADDR_TXCODE: outgoing_code <= wdata_i[3:0]; // [RL2]
                `SSM_ADDR_REPEAT: repeat_count_value <= wdata_i;
                `SSM_ADDR_FASTX:  outgoing_fas_intl_bits <= wdata_i;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `SSM_ADDR_CTRL:   rdata_o <= ctrl_r;
                `SSM_ADDR_RXCODE: rdata_o <= rx_code_r;
                `SSM_ADDR_EXP1:   rdata_o <= {4'h0, exp_r[0]}; // [RL19]
                `SSM_ADDR_EXP2:   rdata_o <= {4'h0, exp_r[1]};
                `SSM_ADDR_EXP3:   rdata_o <= {4'h0, exp_r[2]};
                `SSM_ADDR_TXCODE: rdata_o <= {4'h0, outgoing_code};
                `SSM_ADDR_REPEAT: rdata_o <= repeat_count_value;
                `SSM_ADDR_FASRX:  rdata_o <= captured_fas_intl_bits;
                `SSM_ADDR_FASTX:  rdata_o <= outgoing_fas_intl_bits;
                default:          rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // transmit sequencer: code repeats, then all ones
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state_r <= e1_ssm_pkg::TX_IDLE;
            tx_code_r  <= 4'h0;
            tx_rem_r   <= 8'h00;
        end else if (sw_rst_r) begin
            tx_state_r <= e1_ssm_pkg::TX_IDLE;
            tx_code_r  <= 4'h0;
            tx_rem_r   <= 8'h00;
        end else if (tx_start) begin
            tx_state_r <= e1_ssm_pkg::TX_SEND; // [RL10] [RL15]
            tx_code_r  <= outgoing_code;
            tx_rem_r   <= repeat_count_value;
        end else if (tx_end) begin
            case (tx_state_r)
                e1_ssm_pkg::TX_SEND: begin
                    if (tx_rem_r == 8'h01) begin
                        tx_state_r <= e1_ssm_pkg::TX_ONES; // [RL20]
                    end else if (tx_rem_r != 8'h00) begin
                        tx_rem_r <= tx_rem_r - 8'h01; // [RL14]
                    end
                end
                e1_ssm_pkg::TX_ONES: tx_state_r <= e1_ssm_pkg::TX_ONES;
                e1_ssm_pkg::TX_IDLE: tx_state_r <= e1_ssm_pkg::TX_IDLE;
                default:             tx_state_r <= e1_ssm_pkg::TX_IDLE;
            endcase
        end
    end

    // bit for the coming frame; a start uses the fresh code's msb
    always_comb begin
        tx_ins = tx_start || (tx_state_r != e1_ssm_pkg::TX_IDLE); // [RL16]
        if (tx_start) begin
            tx_bit = outgoing_code[3]; // [RL1]
        end else if (tx_state_r == e1_ssm_pkg::TX_SEND) begin
            tx_bit = tx_code_r[~tx_timing_i.frame_num[2:1]]; // [RL1]
        end else begin
            tx_bit = 1'b1; // [RL20]
        end
        fas_bit = outgoing_fas_intl_bits[~tx_timing_i.frame_num[3:1]];
    end

    // insertion only in the odd frames of each half multiframe
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_out_o <= '0;
        end else if (tx_timing_i.frame_stb) begin
            tx_out_o.sa_ins <= tx_ins && tx_odd && !code_source_select; // [RL4] [RL3]
            tx_out_o.sa_bit <= tx_bit;
            if (tx_ins && tx_odd && code_source_select) begin
                tx_out_o.si_bit <= tx_bit; // [RL18] [RL3]
            end else if (!tx_timing_i.frame_num[0]) begin
                tx_out_o.si_bit <= fas_bit; // [RL18]
            end else begin
                tx_out_o.si_bit <= 1'b1;
            end
        end
    end

    // receive side
    logic       rx_on;
    logic       rx_odd;
    logic       rx_bit;
    logic       rx_done;
    logic [2:0] rx_sh_r;
    logic       rx_err_r;
    logic [3:0] rx_new;
    logic       rx_bad;
    logic [3:0] rx_last_r;
    logic [2:0] rx_cnt_r;
    logic [2:0] rx_cnt_nxt;
    logic       rx_upd;

    assign rx_on  = code_receive_enable // [RL8]
                    && (!code_source_select || (crc_mf_align_en_i
                    && crc_multiframe_config_i != `SSM_CRC_CFG_BAD)); // [RL5]
    assign rx_odd = rx_link_i.frame_stb && rx_link_i.frame_num[0] && rx_on;
    assign rx_bit = code_source_select ? rx_link_i.si_bit
                                       : rx_link_i.sa_bit; // [RL3]
    assign rx_done = rx_odd
                     && (rx_link_i.frame_num[2:0] == `SSM_LAST_FRAME);
    assign rx_new = {rx_sh_r, rx_bit};
    assign rx_bad = rx_err_r || rx_link_i.bit_err;

    // run length of identical error free codes, saturating at seven
    always_comb begin
        if (rx_bad) begin
            rx_cnt_nxt = 3'h0;
        end else if (rx_new == rx_last_r && rx_cnt_r != 3'h7
                     && rx_cnt_r != 3'h0) begin
            rx_cnt_nxt = rx_cnt_r + 3'h1;
        end else if (rx_new == rx_last_r && rx_cnt_r == 3'h7) begin
            rx_cnt_nxt = 3'h7;
        end else begin
            rx_cnt_nxt = 3'h1;
        end
    end

    assign rx_upd = rx_done
                    && rx_cnt_nxt == depth_of(receive_filter_depth)
                    && rx_cnt_r != rx_cnt_nxt; // [RL7]

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_sh_r   <= 3'h0;
            rx_err_r  <= 1'b0;
            rx_last_r <= 4'h0;
            rx_cnt_r  <= 3'h0;
        end else if (sw_rst_r || !rx_on) begin
            rx_sh_r   <= 3'h0;
            rx_err_r  <= 1'b0;
            rx_last_r <= 4'h0;
            rx_cnt_r  <= 3'h0; // [RL8]
        end else if (rx_odd) begin
            rx_sh_r <= rx_new[2:0];
            if (rx_link_i.frame_num[2:0] == `SSM_FIRST_FRAME) begin
                rx_err_r <= rx_link_i.bit_err;
            end else begin
                rx_err_r <= rx_bad;
            end
            if (rx_done) begin
                rx_last_r <= rx_new;
                rx_cnt_r  <= rx_cnt_nxt;
            end
        end
    end

    // message register and event pulses
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_code_r   <= 8'h00;
            rx_events_o <= '0;
        end else if (sw_rst_r) begin
            rx_code_r   <= 8'h00;
            rx_events_o <= '0;
        end else begin
            rx_events_o.rx_code_alarm <= rx_upd; // [RL7]
            rx_events_o.cos_alarm <= rx_upd && rx_new != rx_code_r[3:0]; // [RL13]
            for (int i = 0; i < 3; i++) begin
                rx_events_o.match_alarm[i] <= rx_done && !rx_bad
                    && rx_cnt_nxt == depth_of(match_filter_depth)
                    && rx_cnt_r != rx_cnt_nxt
                    && rx_new == exp_r[i]; // [RL6] [RL12]
            end
            if (rx_upd) begin
                rx_code_r <= {rx_code_r[3:0], rx_new}; // [RL11]
            end
        end
    end

    // fas si capture, loaded only at the multiframe end
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fas_sh_r               <= 8'h00;
            captured_fas_intl_bits <= 8'h00;
        end else if (sw_rst_r) begin
            fas_sh_r               <= 8'h00;
            captured_fas_intl_bits <= 8'h00;
        end else if (rx_link_i.frame_stb) begin
            if (!rx_link_i.frame_num[0]) begin
                fas_sh_r <= {fas_sh_r[6:0], rx_link_i.si_bit};
            end
            if (rx_link_i.frame_num == `SSM_MF_LAST) begin
                captured_fas_intl_bits <= fas_sh_r; // [RL17]
            end
        end
    end

    AST_RX_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !rx_on |=> rx_cnt_r == 3'h0) // [RL8]
        else $error("receive counter runs while disabled");
    AST_SI_CRC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        code_source_select && crc_multiframe_config_i == 2'h3
        |=> rx_cnt_r == 3'h0 && rx_sh_r == 3'h0) // [RL5]
        else $error("si reception with crc config 11");
    AST_SOFT_RST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_ctrl && wdata_i[`SSM_CTRL_RST] |=> ##1
        repeat_count_value == 8'h01 && ctrl_r == 8'h00) // [RL9]
        else $error("soft reset did not restore defaults");
    AST_TX_MSB: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_start && !code_source_select |=> tx_out_o.sa_ins
        && tx_out_o.sa_bit == $past(outgoing_code[3])) // [RL1]
        else $error("code msb not sent first");
    AST_SEND_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_start && !wr_ctrl && !sw_rst_r |=> !code_send_strobe
        && tx_state_r == e1_ssm_pkg::TX_SEND) // [RL10]
        else $error("send bit not cleared at start");
    AST_ONES: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_state_r == e1_ssm_pkg::TX_ONES && !tx_start && tx_odd
        && !code_source_select |=> tx_out_o.sa_bit) // [RL20]
        else $error("ones not sent after repetitions");
    AST_PREV: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_upd && !sw_rst_r |=> rx_code_r[7:4] == $past(rx_code_r[3:0])
        && rx_events_o.rx_code_alarm) // [RL11]
        else $error("previous code not shifted");
    AST_MATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_events_o.match_alarm[0] |-> rx_last_r == exp_r[0]
        && rx_cnt_r == depth_of(match_filter_depth)) // [RL12] [RL6]
        else $error("match alarm without filtered match");
    AST_COS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_events_o.cos_alarm |-> rx_code_r[7:4] != rx_code_r[3:0]) // [RL13]
        else $error("status change with equal codes");
    AST_FAS_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !(rx_link_i.frame_stb && rx_link_i.frame_num == 4'hf) && !sw_rst_r
        |=> $stable(captured_fas_intl_bits)) // [RL17]
        else $error("fas si capture changed mid multiframe");
    AST_RSVD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == `SSM_ADDR_EXP2 |=> rdata_o[7:4] == 4'h0) // [RL19]
        else $error("reserved nibble reads nonzero");
endmodule : e1_ssm_boc_controller

// [verif/e1_framer_model.sv]
`timescale 1ns/1ps
module e1_framer_model #(
    parameter int GAP = 6
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // stimulus from the bench
    input  wire logic [3:0]        code_i,
    input  wire logic              err_i,
    input  wire logic [7:0]        fas_i,
    input  wire logic              slow_i,
    // framer side
    output e1_ssm_pkg::rx_link_s   rx_o,
    output e1_ssm_pkg::tx_timing_s tx_o,
    output logic                   done_o
);
    int         cnt;
    logic [3:0] fn;
    logic [3:0] cur;
    logic [3:0] nfn;
    logic [3:0] c;
    assign nfn = fn + 4'h1;
    // code held from its first bit so a mid-code change cannot tear it
    assign c = (nfn[2:1] == 2'h0) ? code_i : cur;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= 0;
            fn     <= 4'hf;
            cur    <= 4'h0;
            rx_o   <= '0;
            tx_o   <= '0;
            done_o <= 1'b0;
        end else if (cnt == 0) begin
            cnt            <= slow_i ? 2 * GAP : GAP;
            fn             <= nfn;
            tx_o           <= {1'b1, nfn};
            rx_o.frame_stb <= 1'b1;
            rx_o.frame_num <= nfn;
            rx_o.bit_err   <= err_i;
            done_o         <= nfn[0] && nfn[2:1] == 2'h3;
            if (nfn[0]) begin
                // msb first from frame index 1, 4-bit codes
                rx_o.sa_bit <= c[~nfn[2:1]];
                rx_o.si_bit <= c[~nfn[2:1]];
                cur         <= c;
            end else begin
                rx_o.si_bit <= fas_i[~nfn[3:1]];
            end
        end else begin
            cnt            <= cnt - 1;
            tx_o.frame_stb <= 1'b0;
            rx_o.frame_stb <= 1'b0;
            done_o         <= 1'b0;
            // stale bits flip between frames so nothing relies on them
            rx_o.sa_bit    <= ~rx_o.sa_bit;
            rx_o.si_bit    <= ~rx_o.si_bit;
        end
    end
endmodule : e1_framer_model

// [verif/e1_ssm_boc_controller_bench.sv]
`timescale 1ns/1ps
module e1_ssm_boc_controller_bench;
    typedef struct packed {
        logic [3:0] f;
        logic [2:0] v;
        logic [2:0] m;
    } tx_note_s;
    logic                   sys_clk_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic [15:0]            addr = 16'h0000;
    logic [7:0]             wdata = 8'h00;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic                   align = 1'b1;
    logic [1:0]             cfg = 2'h0;
    logic [3:0]             code = 4'h0;
    logic                   err = 1'b0;
    logic                   slow = 1'b0;
    logic [7:0]             fas_rx = 8'h00;
    logic [7:0]             fas_tx = 8'h00;
    logic [7:0]             rdata;
    logic                   done;
    logic                   rd_d = 1'b0;
    logic                   stb_d = 1'b0;
    logic [3:0]             fn_d = 4'h0;
    e1_ssm_pkg::rx_link_s   rx_link;
    e1_ssm_pkg::tx_timing_s tx_tm;
    e1_ssm_pkg::tx_out_s    tx_out;
    e1_ssm_pkg::rx_events_s ev;
    tx_note_s               tn;
    logic [7:0]             rd_q[$];
    tx_note_s               tx_q[$];
    logic [4:0]             ev_q[$];
    int                     mismatches = 0;
    int                     tests_run = 0;
    logic [7:0] rst_tab[9] = '{0, 0, 0, 0, 0, 0, 8'h01, 0, 0};
    logic [7:0] ff_tab[9] = '{0, 0, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hff, 0, 8'hff};
    logic [3:0] t_code[4] = '{4'hb, 4'h2, 4'h8, 4'hf};
    logic [7:0] t_cnt[4] = '{8'h02, 8'h01, 8'h00, 8'h01};
    logic       t_si[4] = '{1'b0, 1'b1, 1'b0, 1'b0};

    always #50 sys_clk_i = ~sys_clk_i;

    e1_framer_model #(.GAP(6)) u_link (
        .clk_i (sys_clk_i), .rst_n_i (rst_n_i), .code_i (code),
        .err_i (err), .fas_i (fas_rx), .slow_i (slow),
        .rx_o (rx_link), .tx_o (tx_tm), .done_o (done)
    );
    e1_ssm_boc_controller u_dut (
        .sys_clk_i (sys_clk_i), .rst_n_i (rst_n_i), .addr_i (addr),
        .wdata_i (wdata), .wr_i (wr), .rd_i (rd), .rdata_o (rdata),
        .rx_link_i (rx_link), .crc_mf_align_en_i (align),
        .crc_multiframe_config_i (cfg), .tx_timing_i (tx_tm),
        .tx_out_o (tx_out), .rx_events_o (ev)
    );

    task automatic tally(input string s, input logic [7:0] e,
                         input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask : tally
    task automatic check_rd(input logic [7:0] e, input logic [7:0] g);
        tally("rdata_o", e, g);
    endtask : check_rd
    task automatic check_tx(input logic [2:0] e, input logic [2:0] g);
        tally("tx_out_o", {5'h00, e}, {5'h00, g});
    endtask : check_tx
    task automatic check_ev(input logic [4:0] e, input logic [4:0] g);
        tally("rx_events_o", {3'h0, e}, {3'h0, g});
    endtask : check_ev

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk_i);
        wr    <= 1'b0;
        @(posedge sys_clk_i);
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk_i);
        rd   <= 1'b0;
        @(posedge sys_clk_i);
    endtask : rd_reg
    // k: 0 received code ends, 1 transmit frame 15, 2 transmit notes used
    task automatic wait_for(input int k, input int n);
        int t;
        t = 0;
        while (n > 0 && t < 20000) begin
            @(posedge sys_clk_i);
            t++;
            if (k == 0 && done === 1'b1) n--;
            if (k == 1 && tx_tm.frame_stb === 1'b1
                && tx_tm.frame_num === 4'hf) n--;
            if (k == 2 && tx_q.size() == 0) n--;
        end
        if (n > 0) begin
            mismatches++;
            $display("mismatch wait %0d exp event got timeout", k);
            stop_test();
        end
    endtask : wait_for
    task automatic tx_run(input logic [3:0] c, input logic [7:0] n,
                          input logic si, input int mfs);
        tx_note_s t;
        logic     b;
        for (int k = 0; k < mfs * 16; k++) begin
            b = (n == 8'h00 || k / 8 < int'(n)) ? c[3 - (k / 2) % 4] : 1'b1;
            t.f = 4'(k);
            t.v = si ? {2'b00, b} : {1'b1, b, 1'b1};
            t.m = si ? 3'b101 : 3'b111;
            if (k % 2 == 0) begin
                t.v = {2'b00, fas_tx[7 - (k % 16) / 2]};
                t.m = 3'b101;
            end
            tx_q.push_back(t);
        end
    endtask : tx_run

    always @(posedge sys_clk_i) begin
        rd_d  <= rd;
        stb_d <= tx_tm.frame_stb;
        fn_d  <= tx_tm.frame_num;
        if (rd_d) check_rd(rd_q.size() ? rd_q.pop_front() : 8'hxx, rdata);
        if (stb_d && tx_q.size() > 0 && tx_q[0].f === fn_d) begin
            tn = tx_q.pop_front();
            check_tx(tn.v & tn.m, 3'(tx_out) & tn.m);
        end
        if (ev !== 5'h00) check_ev(ev_q.size() ? ev_q.pop_front() : 5'h00, ev);
    end

    initial begin
        void'($urandom(32'h42111f07));
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int i = 0; i < 9; i++) rd_reg(16'h0170 + 16'(i), rst_tab[i]);
        rd_reg(16'h0179, 8'h00);
        for (int i = 1; i < 9; i++) wr_reg(16'h0170 + 16'(i), 8'hff);
        for (int i = 0; i < 9; i++) rd_reg(16'h0170 + 16'(i), ff_tab[i]);
        wr_reg(16'h0170, 8'h08);
        repeat (2) @(posedge sys_clk_i);
        for (int i = 0; i < 9; i++) rd_reg(16'h0170 + 16'(i), rst_tab[i]);
        $display("test registers finished");
        fas_tx = 8'($urandom());
        wr_reg(16'h0178, fas_tx);
        // last pass ends a continuous run by count then a new send
        for (int i = 0; i < 4; i++) begin
            wr_reg(16'h0176, t_cnt[i]);
            wr_reg(16'h0175, {4'ha, t_code[i]});
            wait_for(1, 1);
            wr_reg(16'h0170, {t_si[i], 7'h01});
            tx_run(t_code[i], t_cnt[i], t_si[i], 2);
            wait_for(2, 1);
        end
        $display("test transmit finished");
        wr_reg(16'h0170, 8'h00);
        fas_rx <= 8'($urandom());
        code   <= 4'h4;
        wr_reg(16'h0172, 8'h04);
        wr_reg(16'h0173, 8'h02);
        wr_reg(16'h0174, 8'h04);
        wait_for(0, 1);
        ev_q.push_back(5'b11000);
        ev_q.push_back(5'b00101);
        wr_reg(16'h0170, 8'h52);
        wait_for(0, 7);
        rd_reg(16'h0171, 8'h04);
        rd_reg(16'h0177, fas_rx);
        code <= 4'h2;
        slow <= 1'b1;
        ev_q.push_back(5'b11010);
        wr_reg(16'h0170, 8'h10);
        wait_for(0, 2);
        rd_reg(16'h0171, 8'h42);
        err <= 1'b1;
        wait_for(0, 1);
        err <= 1'b0;
        ev_q.push_back(5'b10010);
        wait_for(0, 2);
        wr_reg(16'h0170, 8'h00);
        wait_for(0, 2);
        cfg <= 2'h3;
        wr_reg(16'h0170, 8'h90);
        wait_for(0, 2);
        cfg   <= 2'h0;
        align <= 1'b0;
        wait_for(0, 2);
        align <= 1'b1;
        ev_q.push_back(5'b10010);
        wait_for(0, 2);
        rd_reg(16'h0171, 8'h22);
        wr_reg(16'h0170, 8'h08);
        repeat (2) @(posedge sys_clk_i);
        for (int i = 0; i < 9; i++) rd_reg(16'h0170 + 16'(i), rst_tab[i]);
        $display("test receive finished");
        stop_test();
    end
endmodule : e1_ssm_boc_controller_bench
